/* hw/pulse_counter_pkg.sv */
/*
 Shared constants and types of the dual-channel pulse counter.
 Assumes a 40 MHz core clock and a 4-bit word-addressed register port.
*/
package pulse_counter_pkg;

    localparam int CLK_NS  = 25;
    // on-time and sample-time registers count in 1 us ticks
    localparam int TICK_NS = 1000;
    localparam logic [5:0] TICK_CYC = 6'(TICK_NS / CLK_NS);

    localparam logic [3:0] ADDR_CFG    = 4'h0;
    localparam logic [3:0] ADDR_CTRL   = 4'h1;
    localparam logic [3:0] ADDR_MAX0   = 4'h2;
    localparam logic [3:0] ADDR_MAX1   = 4'h3;
    localparam logic [3:0] ADDR_SETP0  = 4'h4;
    localparam logic [3:0] ADDR_SETP1  = 4'h5;
    localparam logic [3:0] ADDR_ONTIME = 4'h6;
    localparam logic [3:0] ADDR_RATE0  = 4'h7;
    localparam logic [3:0] ADDR_RATE1  = 4'h8;
    localparam logic [3:0] ADDR_CNT0   = 4'h9;
    localparam logic [3:0] ADDR_CNT1   = 4'ha;
    localparam logic [3:0] ADDR_PREV0  = 4'hb;
    localparam logic [3:0] ADDR_PREV1  = 4'hc;
    localparam logic [3:0] ADDR_RVAL0  = 4'hd;
    localparam logic [3:0] ADDR_RVAL1  = 4'he;
    localparam logic [3:0] ADDR_STAT   = 4'hf;

    localparam int CTRL_SWEN_LSB   = 0;
    localparam int CTRL_PRESET_LSB = 2;
    localparam int CFG_W           = 8;
    localparam int ONT_W           = 18;

    localparam logic [31:0] MAX16   = 32'h0000ffff;
    localparam logic [31:0] MAX_RST = 32'h0000ffff;

    typedef enum logic [1:0] {
        ARR_TWO16     = 2'h0,
        ARR_TWO16_OUT = 2'h1,
        ARR_ONE32_OUT = 2'h3,
        ARR_TWO32     = 2'h2
    } arr_t;

    typedef struct packed {
        logic       out_disable;
        logic [1:0] trig_sel;     // bit0 setpoint, bit1 maximum
        logic       fault_keep;   // outputs keep running on bus loss
        logic       rate_mode;
        arr_t       arr;
        logic       quad;
    } cfg_t;

    typedef struct packed {
        logic        ch;
        logic        out_b;
        logic [15:0] on_time;
    } ontime_t;

    typedef struct packed {
        logic a;
        logic b;
        logic dir_up;
        logic enable;
        logic preset;
        logic out_reset;
    } field_pins_t;

    typedef struct packed {
        logic step;
        logic up;
        logic enable;
        logic preset;
        logic out_reset;
    } field_ev_t;

endpackage

/* hw/field_input_decoder.sv */
/*
 Field input conditioning for one counter channel: two-stage
 synchronisers on every terminal, then edge and level decoding.
 Assumes raw terminal levels, asynchronous to i_clock.
*/
`timescale 1ns/1ps
module field_input_decoder import pulse_counter_pkg::*; (
    // clock and control
    input  wire logic        i_clock,
    input  wire logic        i_reset,
    input  wire logic        i_clk_en,
    input  wire logic        i_quad,
    // terminals
    input  wire field_pins_t i_pins,
    // decoded events
    output field_ev_t        o_ev
);
    typedef struct packed {
        field_pins_t s1;
        field_pins_t s2;
        field_pins_t last;
    } sync_t;

    sync_t r_reg;
    sync_t r_next;

    always_comb begin
        r_next      = r_reg;
        r_next.s1   = i_pins;
        r_next.s2   = r_reg.s1;
        r_next.last = r_reg.s2;
    end

    always_ff @(posedge i_clock) begin
        if (i_reset) begin
            r_reg <= '0;
        end else if (i_clk_en) begin
            r_reg <= r_next;
        end
    end

    // quadrature counts every edge of both phases, pulse mode rising a only
    always_comb begin
        o_ev.step      = i_quad ? ((r_reg.s2.a ^ r_reg.last.a) | (r_reg.s2.b ^ r_reg.last.b))
                                : (r_reg.s2.a & ~r_reg.last.a);
        o_ev.up        = r_reg.s2.dir_up;
        o_ev.enable    = r_reg.s2.enable;
        o_ev.preset    = r_reg.s2.preset & ~r_reg.last.preset;
        o_ev.out_reset = r_reg.s2.out_reset & ~r_reg.last.out_reset;
    end

endmodule // field_input_decoder

/* hw/pulse_counter.sv */
/*
 Dual-channel pulse / quadrature counter with preset, rate sampling and
 timed or latched outputs, reached over a plain register port.
 Assumes a bus master on i_clock; field terminals are asynchronous.
*/
// Behaviour
// - a counter advances only while hardware and software enables are both high
// - new maximum or any preset sets that counter's software enable
// - up direction: preset or maximum load clears the counter to zero
// - up counting wraps from maximum to zero on the next pulse
// - down direction: preset or maximum load loads the maximum
// - down counting wraps from zero back to the maximum
// - disabled counters hold their value and ignore pulses
// - of hardware and software presets the latest one decides the state
// - writing a maximum or sample time presets that counter
// - a field input selects the count direction
// - presets come from a field input or a software command
// - software picks pulse or quadrature, widths with outputs, count or rate
// - an option keeps or inhibits outputs when the backplane link is lost
// - outputs fire on setpoint, maximum, both, or are disabled
// - in count mode an output asserts when its trigger point is reached
// - no outputs in two-32-bit arrangement or rate mode
// - one programmed on-time, for one channel and one output only
// - latched outputs clear by field reset, or when the controller stops
// - last completed rate sample stays readable during counting
// - value from just before a preset stays readable
// - trigger to output change stays well under 40 us
`timescale 1ns/1ps
module pulse_counter import pulse_counter_pkg::*; (
    // clock and reset
    input  wire logic              i_clock,
    input  wire logic              i_reset,
    input  wire logic              i_clk_en,
    // register port
    input  wire logic [3:0]        i_addr,
    input  wire logic [31:0]       i_wdata,
    input  wire logic              i_wr,
    input  wire logic              i_rd,
    output logic      [31:0]       o_rdata,
    // field terminals, channel 0 and 1
    input  wire field_pins_t [1:0] i_field,
    // controller side status
    input  wire logic              i_bus_ok,
    input  wire logic              i_ctrl_run,
    // outputs {2B, 2A, 1B, 1A}
    output logic      [3:0]        o_out
);
    typedef struct packed {
        cfg_t             cfg;
        ontime_t          ont;
        logic [1:0]       sw_en;
        logic [1:0][31:0] maxv;
        logic [1:0][31:0] setp;
        logic [1:0][31:0] rate_time;
        logic [1:0][31:0] cnt;
        logic [1:0][31:0] prev;
        logic [1:0][31:0] acc;
        logic [1:0][31:0] rate_val;
        logic [1:0][31:0] tmr;
        logic [5:0]       tick_div;
        logic [15:0]      on_cnt;
        logic [3:0]       raw;
        logic [3:0]       drive;
        logic [31:0]      rdata;
    } state_t;

    state_t r_reg;
    state_t r_next;

    field_ev_t [1:0]  ev;
    logic [1:0]       wr_max;
    logic [1:0]       wr_rate;
    logic [1:0]       sw_preset;
    logic [1:0]       load;
    logic [1:0]       run;
    logic [1:0]       active;
    logic [1:0]       out_ok;
    logic [1:0][31:0] em;
    logic [1:0][31:0] em_new;
    logic [1:0]       timed_idx;
    logic             tick;

    function automatic logic [31:0] eff_max(arr_t a, logic [31:0] m);
        return (a == ARR_TWO16 || a == ARR_TWO16_OUT) ? (m & MAX16) : m;
    endfunction

    function automatic logic [31:0] step_val(logic up, logic [31:0] c, logic [31:0] m);
        if (up) begin
            return (c >= m) ? 32'h0 : 32'(c + 32'h1);
        end
        return (c == 32'h0 || c > m) ? m : 32'(c - 32'h1);
    endfunction

    function automatic logic [31:0] preset_val(logic up, logic [31:0] m);
        return up ? 32'h0 : m;
    endfunction

    genvar g;
    generate
        for (g = 0; g < 2; g++) begin : g_in
            field_input_decoder u_dec (
                .i_clock  (i_clock),
                .i_reset  (i_reset),
                .i_clk_en (i_clk_en),
                .i_quad   (r_reg.cfg.quad),
                .i_pins   (i_field[g]),
                .o_ev     (ev[g])
            );
        end
    endgenerate

    assign wr_max    = {i_wr && i_addr == ADDR_MAX1, i_wr && i_addr == ADDR_MAX0};
    assign wr_rate   = {i_wr && i_addr == ADDR_RATE1, i_wr && i_addr == ADDR_RATE0};
    assign sw_preset = (i_wr && i_addr == ADDR_CTRL) ?
                       i_wdata[CTRL_PRESET_LSB +: 2] : 2'h0;
    // hardware and software presets are single events on one clock, so
    // applying each as it comes makes the later one win
    assign load      = {ev[1].preset, ev[0].preset} | sw_preset
                     | wr_max | wr_rate;
    // counter 0 idles when the pair is run as one 32-bit counter
    assign active    = {1'b1, r_reg.cfg.arr != ARR_ONE32_OUT};
    assign run       = {ev[1].enable, ev[0].enable} & r_reg.sw_en & active;
    assign out_ok[0] = r_reg.cfg.arr == ARR_TWO16_OUT && !r_reg.cfg.rate_mode
                     && !r_reg.cfg.out_disable;
    assign out_ok[1] = (r_reg.cfg.arr == ARR_TWO16_OUT || r_reg.cfg.arr == ARR_ONE32_OUT)
                     && !r_reg.cfg.rate_mode && !r_reg.cfg.out_disable;
    assign timed_idx = {r_reg.ont.ch, r_reg.ont.out_b};
    assign tick      = r_reg.tick_div == 6'(TICK_CYC - 6'h1);
    assign em[0]     = eff_max(r_reg.cfg.arr, r_reg.maxv[0]);
    assign em[1]     = eff_max(r_reg.cfg.arr, r_reg.maxv[1]);
    assign em_new[0] = eff_max(r_reg.cfg.arr, wr_max[0] ? i_wdata : r_reg.maxv[0]);
    assign em_new[1] = eff_max(r_reg.cfg.arr, wr_max[1] ? i_wdata : r_reg.maxv[1]);

    always_comb begin
        r_next          = r_reg;
        r_next.rdata    = 32'h0;
        r_next.tick_div = tick ? 6'h0 : 6'(r_reg.tick_div + 6'h1);

        // register writes
        if (i_wr) begin
            case (i_addr)
                ADDR_CFG:    r_next.cfg          = cfg_t'(i_wdata[CFG_W-1:0]);
                ADDR_CTRL:   r_next.sw_en        = i_wdata[CTRL_SWEN_LSB +: 2];
                ADDR_MAX0:   r_next.maxv[0]      = i_wdata;
                ADDR_MAX1:   r_next.maxv[1]      = i_wdata;
                ADDR_SETP0:  r_next.setp[0]      = i_wdata;
                ADDR_SETP1:  r_next.setp[1]      = i_wdata;
                ADDR_ONTIME: r_next.ont          = ontime_t'(i_wdata[ONT_W-1:0]);
                ADDR_RATE0:  r_next.rate_time[0] = i_wdata;
                ADDR_RATE1:  r_next.rate_time[1] = i_wdata;
                default:     r_next.rdata        = 32'h0;
            endcase
        end

        // timed output runs down in 1 us ticks, then drops
        if (tick && r_reg.on_cnt != 16'h0) begin
            r_next.on_cnt = 16'(r_reg.on_cnt - 16'h1);
            if (r_reg.on_cnt == 16'h1) begin
                r_next.raw[timed_idx] = 1'b0;
            end
        end
        // a stopped controller drops every latched output; an on-time of
        // zero leaves the timed output latched, so it is dropped as well
        if (!i_ctrl_run) begin
            for (int i = 0; i < 4; i++) begin
                if (2'(i) != timed_idx || r_reg.ont.on_time == 16'h0) begin
                    r_next.raw[i] = 1'b0;
                end
            end
        end

        for (int c = 0; c < 2; c++) begin
            if (ev[c].out_reset) begin
                r_next.raw[2*c +: 2] = 2'h0;
            end
            if (load[c]) begin
                r_next.prev[c]  = r_reg.cnt[c];
                r_next.cnt[c]   = preset_val(ev[c].up, em_new[c]);
                r_next.sw_en[c] = 1'b1;
                r_next.acc[c]   = 32'h0;
                r_next.tmr[c]   = 32'h0;
                if (wr_rate[c]) begin
                    r_next.rate_val[c] = 32'h0;
                end
            end else if (run[c]) begin
                if (ev[c].step) begin
                    r_next.cnt[c] = step_val(ev[c].up, r_reg.cnt[c], em[c]);
                    // triggers fire on the cycle the count lands, and drive is built from
                    // the new raw value, so the output changes on the same clock as the count
                    if (out_ok[c] && !r_reg.cfg.rate_mode) begin
                        if (r_reg.cfg.trig_sel[0] && r_next.cnt[c] == r_reg.setp[c]) begin
                            r_next.raw[2*c] = 1'b1;
                            if (timed_idx == 2'(2*c)) begin
                                r_next.on_cnt = r_reg.ont.on_time;
                            end
                        end
                        if (r_reg.cfg.trig_sel[1] && r_next.cnt[c] == em[c]) begin
                            r_next.raw[2*c+1] = 1'b1;
                            if (timed_idx == 2'(2*c+1)) begin
                                r_next.on_cnt = r_reg.ont.on_time;
                            end
                        end
                    end
                end
                if (r_reg.cfg.rate_mode) begin
                    r_next.acc[c] = 32'(r_reg.acc[c] + {31'h0, ev[c].step});
                    if (tick && r_reg.rate_time[c] != 32'h0) begin
                        if (32'(r_reg.tmr[c] + 32'h1) >= r_reg.rate_time[c]) begin
                            r_next.rate_val[c] = r_next.acc[c];
                            r_next.acc[c]      = 32'h0;
                            r_next.tmr[c]      = 32'h0;
                        end else begin
                            r_next.tmr[c] = 32'(r_reg.tmr[c] + 32'h1);
                        end
                    end
                end
            end
            // a disabled counter keeps cnt untouched
        end

        // bus loss inhibits outputs unless configured to keep them
        r_next.drive = r_next.raw & {out_ok[1], out_ok[1], out_ok[0], out_ok[0]}
                     & {4{i_bus_ok || r_reg.cfg.fault_keep}};

        if (i_rd) begin
            case (i_addr)
                ADDR_CFG:    r_next.rdata = {24'h0, r_reg.cfg};
                ADDR_CTRL:   r_next.rdata = {30'h0, r_reg.sw_en};
                ADDR_MAX0:   r_next.rdata = r_reg.maxv[0];
                ADDR_MAX1:   r_next.rdata = r_reg.maxv[1];
                ADDR_SETP0:  r_next.rdata = r_reg.setp[0];
                ADDR_SETP1:  r_next.rdata = r_reg.setp[1];
                ADDR_ONTIME: r_next.rdata = {14'h0, r_reg.ont};
                ADDR_RATE0:  r_next.rdata = r_reg.rate_time[0];
                ADDR_RATE1:  r_next.rdata = r_reg.rate_time[1];
                ADDR_CNT0:   r_next.rdata = r_reg.cnt[0];
                ADDR_CNT1:   r_next.rdata = r_reg.cnt[1];
                ADDR_PREV0:  r_next.rdata = r_reg.prev[0];
                ADDR_PREV1:  r_next.rdata = r_reg.prev[1];
                ADDR_RVAL0:  r_next.rdata = r_reg.rate_val[0];
                ADDR_RVAL1:  r_next.rdata = r_reg.rate_val[1];
                ADDR_STAT:   r_next.rdata = {20'h0, r_reg.drive, ev[1].up, ev[0].up,
                                             run, ev[1].enable, ev[0].enable,
                                             r_reg.sw_en};
                default:     r_next.rdata = 32'h0;
            endcase
        end
    end

    always_ff @(posedge i_clock) begin
        if (i_reset) begin
            r_reg      <= '0;
            r_reg.maxv <= {MAX_RST, MAX_RST};
        end else if (i_clk_en) begin
            r_reg <= r_next;
        end
    end

    assign o_rdata = r_reg.rdata;
    assign o_out   = r_reg.drive;

    default clocking cb @(posedge i_clock);
    endclocking
    default disable iff (i_reset);

    property p_hold;
        i_clk_en && !run[0] && !load[0] |=> $stable(r_reg.cnt[0]);
    endproperty
    a_hold: assert property (p_hold) else $error("disabled counter moved");

    property p_gate;
        i_clk_en && !load[1] && ev[1].step && !(ev[1].enable && r_reg.sw_en[1])
            |=> r_reg.cnt[1] == $past(r_reg.cnt[1]);
    endproperty
    a_gate: assert property (p_gate) else $error("count without both enables");

    property p_up_wrap;
        i_clk_en && run[0] && ev[0].step && ev[0].up && !load[0]
            && r_reg.cnt[0] == em[0] |=> r_reg.cnt[0] == 32'h0;
    endproperty
    a_up_wrap: assert property (p_up_wrap) else $error("up wrap not to zero");

    property p_dn_wrap;
        i_clk_en && run[0] && ev[0].step && !ev[0].up && !load[0]
            && r_reg.cnt[0] == 32'h0 |=> r_reg.cnt[0] == $past(em[0]);
    endproperty
    a_dn_wrap: assert property (p_dn_wrap) else $error("down wrap not to max");

    property p_pre_up;
        i_clk_en && load[0] && ev[0].up |=> r_reg.cnt[0] == 32'h0;
    endproperty
    a_pre_up: assert property (p_pre_up) else $error("up preset not zero");

    property p_pre_dn;
        i_clk_en && load[1] && !ev[1].up && !wr_max[1]
            |=> r_reg.cnt[1] == $past(em[1]);
    endproperty
    a_pre_dn: assert property (p_pre_dn) else $error("down preset not max");

    property p_swen;
        i_clk_en && (ev[0].preset || wr_max[0]) |=> r_reg.sw_en[0];
    endproperty
    a_swen: assert property (p_swen) else $error("soft enable not set");

    property p_prev;
        i_clk_en && load[1] |=> r_reg.prev[1] == $past(r_reg.cnt[1]);
    endproperty
    a_prev: assert property (p_prev) else $error("old count lost");

    property p_auto;
        i_clk_en && wr_rate[0] && !i_rd ##1 i_clk_en && i_rd && i_addr == ADDR_PREV0
            |=> o_rdata == $past(r_reg.cnt[0], 2);
    endproperty
    a_auto: assert property (p_auto) else $error("sample time write no preset");

    property p_no_out;
        i_clk_en && (r_reg.cfg.rate_mode || r_reg.cfg.arr == ARR_TWO32)
            |=> o_out == 4'h0;
    endproperty
    a_no_out: assert property (p_no_out) else $error("output in no-output mode");

    property p_fault;
        i_clk_en && !i_bus_ok && !r_reg.cfg.fault_keep |=> o_out == 4'h0;
    endproperty
    a_fault: assert property (p_fault) else $error("output during bus fault");

    property p_latch;
        i_clk_en && i_ctrl_run && !ev[0].out_reset && r_reg.raw[0]
            && timed_idx != 2'h0 |=> r_reg.raw[0];
    endproperty
    a_latch: assert property (p_latch) else $error("latched output dropped");

    // the idle half of a single 32-bit counter moves only by preset
    property p_one32;
        i_clk_en && r_reg.cfg.arr == ARR_ONE32_OUT && !load[0] |=> $stable(r_reg.cnt[0]);
    endproperty
    a_one32: assert property (p_one32) else $error("idle channel counted");

    // the timed output drops on the tick that ends its on-time
    property p_timed_end;
        i_clk_en && tick && r_reg.on_cnt == 16'h1 && !i_wr && !ev[r_reg.ont.ch].step
            |=> !r_reg.raw[timed_idx];
    endproperty
    a_timed_end: assert property (p_timed_end) else $error("on-time overrun");

endmodule // pulse_counter

/* testbench/field_encoder_model.sv */
/*
 Field side model: encoder pulses and terminal levels for both channels.
 Assumes the testbench calls its tasks; chans picks the channels that see them.
*/
`timescale 1ns/1ps
module field_encoder_model import pulse_counter_pkg::*; (
    // clock
    input  wire logic         i_clock,
    // terminals towards the counter
    output field_pins_t [1:0] o_field
);
    // one set of terminal levels, fanned out to the selected channels
    field_pins_t pins  = '0;
    logic [1:0]  chans = 2'h1;

    assign o_field = {pins & {6{chans[1]}}, pins & {6{chans[0]}}};

    // each level is held 4 cycles, above the 2 cycles the synchronisers need
    task automatic pulses(input int n);
        repeat (n) begin
            @(posedge i_clock);
            pins.a <= 1'b1;
            repeat (4) @(posedge i_clock);
            pins.a <= 1'b0;
            repeat (3) @(posedge i_clock);
        end
        repeat (6) @(posedge i_clock);
    endtask

    // one encoder period: a rises, b rises, a falls, b falls, 3 cycles apart
    task automatic quad(input int n);
        repeat (n) begin
            @(posedge i_clock);
            pins.a <= 1'b1;
            repeat (3) @(posedge i_clock);
            pins.b <= 1'b1;
            repeat (3) @(posedge i_clock);
            pins.a <= 1'b0;
            repeat (3) @(posedge i_clock);
            pins.b <= 1'b0;
            repeat (2) @(posedge i_clock);
        end
        repeat (6) @(posedge i_clock);
    endtask

    task automatic strobe(input bit rst_out);
        @(posedge i_clock);
        if (rst_out) pins.out_reset <= 1'b1;
        else pins.preset <= 1'b1;
        repeat (4) @(posedge i_clock);
        pins.out_reset <= 1'b0;
        pins.preset <= 1'b0;
        repeat (6) @(posedge i_clock);
    endtask

    task automatic level(input bit en, input bit up);
        @(posedge i_clock);
        pins.enable <= en;
        pins.dir_up <= up;
        repeat (4) @(posedge i_clock);
    endtask
endmodule // field_encoder_model

/* testbench/testbench.sv */
/*
 Self-checking testbench of the dual-channel pulse counter.
 Assumes the package, the design and the field encoder model compile first.
*/
`timescale 1ns/1ps
module testbench import pulse_counter_pkg::*;;
    logic              i_clock    = 1'b0;
    logic              i_reset    = 1'b1;
    logic              i_clk_en   = 1'b1;
    logic              i_wr       = 1'b0;
    logic              i_rd       = 1'b0;
    logic              i_bus_ok   = 1'b1;
    logic              i_ctrl_run = 1'b1;
    logic [3:0]        i_addr     = 4'h0;
    logic [31:0]       i_wdata    = 32'h0;
    logic [31:0]       o_rdata;
    logic [3:0]        o_out;
    field_pins_t [1:0] field;
    int                bad_count  = 0;
    int                n_tests    = 0;

    always #12.5 i_clock = ~i_clock;

    pulse_counter i_pulse_counter (
        .i_clock(i_clock), .i_reset(i_reset), .i_clk_en(i_clk_en),
        .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd),
        .o_rdata(o_rdata), .i_field(field), .i_bus_ok(i_bus_ok),
        .i_ctrl_run(i_ctrl_run), .o_out(o_out)
    );

    field_encoder_model i_field_encoder_model (.i_clock(i_clock), .o_field(field));

    task automatic complete_run;
        if (bad_count == 0 && n_tests > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask

    task automatic check(input logic [31:0] got, input logic [31:0] exp, input string what);
        n_tests++;
        if (got !== exp) begin
            bad_count++;
            $display("MISMATCH at %0t: %s got %h expected %h", $time, what, got, exp);
        end
    endtask

    task automatic cyc(input int n);
        repeat (n) @(posedge i_clock);
    endtask

    task automatic wr(input logic [3:0] a, input logic [31:0] d);
        @(posedge i_clock);
        i_wr <= 1'b1;
        i_addr <= a;
        i_wdata <= d;
        @(posedge i_clock);
        i_wr <= 1'b0;
    endtask

    // read data stand only in the cycle after the strobe edge
    task automatic rdc(input logic [3:0] a, input logic [31:0] exp, input string what);
        @(posedge i_clock);
        i_rd <= 1'b1;
        i_addr <= a;
        @(posedge i_clock);
        i_rd <= 1'b0;
        #1 check(o_rdata, exp, what);
    endtask

    // write followed at once by a read, no idle cycle between the strobes
    task automatic wrrd(input logic [3:0] a, input logic [31:0] d, input logic [3:0] ra,
                        input logic [31:0] exp, input string what);
        @(posedge i_clock);
        i_wr <= 1'b1;
        i_addr <= a;
        i_wdata <= d;
        @(posedge i_clock);
        i_wr <= 1'b0;
        i_rd <= 1'b1;
        i_addr <= ra;
        @(posedge i_clock);
        i_rd <= 1'b0;
        #1 check(o_rdata, exp, what);
    endtask

    task automatic outc(input logic [3:0] e, input string what);
        #1 check(32'(o_out), 32'(e), what);
    endtask

    task automatic t_reset;
        rdc(ADDR_MAX0, MAX_RST, "max reset value");
        rdc(ADDR_CNT0, 32'h0, "count reset value");
        wr(ADDR_CNT0, 32'h7);
        rdc(ADDR_CNT0, 32'h0, "count is read only");
    endtask

    task automatic t_up;
        wr(ADDR_CFG, 32'h22);
        wr(ADDR_SETP0, 32'h2);
        // up direction first, so the maximum load clears the count
        i_field_encoder_model.level(1'b0, 1'b1);
        wr(ADDR_MAX0, 32'h5);
        rdc(ADDR_CTRL, 32'h1, "sw enable after max load");
        i_field_encoder_model.pulses(2);
        rdc(ADDR_CNT0, 32'h0, "counted with hw enable low");
        i_field_encoder_model.level(1'b1, 1'b1);
        i_field_encoder_model.pulses(2);
        rdc(ADDR_CNT0, 32'h2, "count up");
        outc(4'h1, "setpoint output");
        i_field_encoder_model.pulses(4);
        rdc(ADDR_CNT0, 32'h0, "wrap to zero");
        outc(4'h1, "output latched");
        i_field_encoder_model.strobe(1'b1);
        outc(4'h0, "field reset of output");
        i_field_encoder_model.pulses(2);
        cyc(1);
        i_bus_ok <= 1'b0;
        cyc(3);
        outc(4'h0, "output on bus loss");
        i_bus_ok <= 1'b1;
        cyc(3);
        outc(4'h1, "output after bus return");
        i_ctrl_run <= 1'b0;
        cyc(3);
        outc(4'h0, "latched output on stop");
        i_ctrl_run <= 1'b1;
        wr(ADDR_CTRL, 32'h0);
        i_field_encoder_model.pulses(2);
        rdc(ADDR_CNT0, 32'h2, "frozen while disabled");
    endtask

    task automatic t_down;
        i_field_encoder_model.level(1'b1, 1'b0);
        i_field_encoder_model.strobe(1'b0);
        rdc(ADDR_CNT0, 32'h5, "down preset to max");
        rdc(ADDR_PREV0, 32'h2, "value before preset");
        rdc(ADDR_CTRL, 32'h1, "sw enable after hw preset");
        i_field_encoder_model.pulses(6);
        rdc(ADDR_CNT0, 32'h5, "down wrap to max");
        i_field_encoder_model.level(1'b1, 1'b1);
        wr(ADDR_CTRL, 32'h4);
        rdc(ADDR_CNT0, 32'h0, "later sw preset wins");
        rdc(ADDR_CTRL, 32'h1, "sw enable after sw preset");
        i_field_encoder_model.pulses(1);
        wrrd(ADDR_RATE0, 32'h0, ADDR_PREV0, 32'h1, "count before rate write");
        rdc(ADDR_CNT0, 32'h0, "preset by sample time write");
    endtask

    // two 32-bit counters, rate mode, outputs disabled: none may drive an output
    task automatic t_no_out;
        logic [7:0] cfgs [3];
        cfgs = '{8'h24, 8'h2a, 8'ha2};
        // channel 1 sees the same pulses but has no software enable yet
        i_field_encoder_model.chans <= 2'h3;
        for (int k = 0; k < 3; k++) begin
            wr(ADDR_CFG, 32'(cfgs[k]));
            wr(ADDR_CTRL, 32'h5);
            i_field_encoder_model.strobe(1'b1);
            i_field_encoder_model.pulses(2);
            outc(4'h0, "output suppressed");
        end
        rdc(ADDR_CNT1, 32'h0, "channel 1 without sw enable");
    endtask

    // single 32-bit counter on channel 1: quadrature, maximum trigger, timed output
    task automatic t_timed;
        wr(ADDR_CFG, 32'h57);
        wr(ADDR_ONTIME, 32'h30002);
        wr(ADDR_CTRL, 32'h4);
        wr(ADDR_MAX1, 32'h4);
        i_field_encoder_model.quad(1);
        i_bus_ok <= 1'b0;
        cyc(3);
        outc(4'h8, "timed output kept on bus loss");
        i_bus_ok <= 1'b1;
        rdc(ADDR_CNT1, 32'h4, "quadrature count");
        rdc(ADDR_CNT0, 32'h0, "idle channel in 32-bit mode");
        cyc(90);
        outc(4'h0, "timed output ends");
        i_clk_en <= 1'b0;
        i_field_encoder_model.quad(1);
        i_clk_en <= 1'b1;
        rdc(ADDR_CNT1, 32'h4, "frozen with clock enable low");
    endtask

    // any 40-cycle interval of a period-8 pulse train holds exactly 5 rising edges
    task automatic t_rate;
        wr(ADDR_CFG, 32'h08);
        wr(ADDR_RATE0, 32'h1);
        fork
            i_field_encoder_model.pulses(15);
            begin
                cyc(100);
                rdc(ADDR_RVAL0, 32'h5, "rate sample");
            end
        join
    endtask

    initial begin
        repeat (50000) @(posedge i_clock);
        bad_count++;
        $display("MISMATCH at %0t: run did not finish", $time);
        complete_run();
    end

    initial begin
        cyc(10);
        i_reset <= 1'b0;
        t_reset();
        t_up();
        t_down();
        t_no_out();
        t_rate();
        t_timed();
        complete_run();
    end
endmodule // testbench
